// ==== rtl/hpms_host_port.sv ====
// Purpose: Host port front end: strap decode, pin sharing, register access
// Assumes: Serial bit framing lives in a separate engine fed from the pin map
// Notes: Parallel strobes are sampled through three flops, so a host that
//        ignores wait must keep each cycle longer than the sampling latency
// Notes on behaviour
// - Strap pins pick one of five protocols
// - Serial modes free parallel pins as GPIO
// - Low data pins carry serial lines, address
// - Config bit 0 selects 8/16 bit width
// - Active-low wait shows transfer not complete
// - One status plus 256 indexed registers
// - Write: index cycle then data cycle
// - Read: index cycle then data read
// - Image data goes to display memory
// - Select and direction decide cycle meaning
// - Memory port writes advance memory address
`timescale 1ns/1ps
module hpms_host_port (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [2:0] host_protocol_strap,
   input wire logic [15:0] host_data_bus_in,
   output logic [15:0] host_data_bus_out,
   output logic [15:0] host_data_bus_oe_n,
   input wire logic [3:0] ctrl_pin_in,
   output logic [3:0] ctrl_pin_out,
   output logic [3:0] ctrl_pin_oe_n,
   output logic wait_n,
   input wire logic irq_n,
   output logic int_n,
   input wire logic [7:0] status_in,
   output logic [4:0] mode_onehot,
   output logic is_serial,
   output logic serial_clock,
   output logic serial_data_in,
   output logic serial_chip_select_n,
   output logic [5:0] i2c_address_strap,
   input wire logic serial_data_out,
   input wire logic serial_data_oe,
   output logic [7:0] aux_port_upper_in,
   input wire logic [7:0] aux_port_upper_out,
   input wire logic [7:0] aux_port_upper_oe,
   output logic [3:0] aux_port_ctrl_in,
   input wire logic [3:0] aux_port_ctrl_out,
   input wire logic [3:0] aux_port_ctrl_oe,
   output logic core_restart,
   input wire logic [23:0] mem_start_addr,
   output logic mem_wr_valid,
   output logic [15:0] mem_wr_data,
   output logic [23:0] mem_wr_addr,
   input wire logic mem_wr_ready
);
   // Whole block state in one record
   typedef struct packed {
      logic strap_valid; // Strap caught after reset release
      logic [2:0] settle; // Clocks since release, until the strap is taken
      hpms_pkg::hpms_mode_t mode; // Chosen protocol
      hpms_pkg::hpms_state_t st; // Access sequencer
      logic [7:0] index; // Register index from the last address cycle
      logic [hpms_pkg::NUM_REGS-1:0][7:0] regs; // Indexed registers
      logic [15:0] dout; // Read data latch
      logic [15:0] mdata; // Pending memory word
      logic [23:0] maddr; // Display memory address
      logic mvalid; // Memory write pending
      logic restart; // One-cycle core restart pulse
   } hpms_state_rec_t;

   hpms_state_rec_t cur_ff; // Registered state
   hpms_state_rec_t nxt_cur; // Next state

   logic [2:0] strap_s; // Filtered strap pins
   logic [15:0] db_s; // Filtered data pins
   logic [3:0] ctl_s; // Filtered cs, rd/en, wr/rw, select
   logic strobe; // A parallel cycle is active
   logic rd_dir; // Active cycle is a read
   logic wide; // 16-bit transfers chosen
   logic par_mode; // A parallel protocol is in use

   hpms_pin_sync #(.W(3)) u_sync_strap (
      .clk(clk), .sys_rst(sys_rst), .pin(host_protocol_strap), .q(strap_s)
   );
   hpms_pin_sync #(.W(16)) u_sync_db (
      .clk(clk), .sys_rst(sys_rst), .pin(host_data_bus_in), .q(db_s)
   );
   hpms_pin_sync #(.W(4)) u_sync_ctl (
      .clk(clk), .sys_rst(sys_rst), .pin(ctrl_pin_in), .q(ctl_s)
   );

   // Decode strap; bit 0 only matters for the serial pair
   function automatic hpms_pkg::hpms_mode_t decode_strap(input logic [2:0] s);
      case (s[2:1])
         2'b00: decode_strap = hpms_pkg::HPMS_M8080;
         2'b01: decode_strap = hpms_pkg::HPMS_M6800;
         2'b10: decode_strap = (s == hpms_pkg::STRAP_SPI4) ? hpms_pkg::HPMS_MSPI4
                                                          : hpms_pkg::HPMS_MSPI3;
         default: decode_strap = hpms_pkg::HPMS_MI2C;
      endcase
   endfunction

   // Strobe and direction per parallel flavour; ctl = {sel, wr/rw, rd/en, cs}
   always_comb begin
      par_mode = cur_ff.strap_valid && (cur_ff.mode == hpms_pkg::HPMS_M8080 ||
                                        cur_ff.mode == hpms_pkg::HPMS_M6800);
      if (cur_ff.mode == hpms_pkg::HPMS_M6800) begin
         strobe = par_mode && !ctl_s[0] && ctl_s[1];
         rd_dir = ctl_s[2];
      end else begin
         strobe = par_mode && !ctl_s[0] && (!ctl_s[1] || !ctl_s[2]);
         rd_dir = !ctl_s[1];
      end
      wide = cur_ff.regs[hpms_pkg::IDX_CFG][hpms_pkg::BIT_WIDE];
   end

   // Sequencer and register file
   always_comb begin
      nxt_cur = cur_ff;
      nxt_cur.restart = 1'b0;
      // Strap caught once, after the filter has passed the pins; taking it
      // earlier would read the cleared filter and always pick 8080
      if (!cur_ff.strap_valid) begin
         if (cur_ff.settle == hpms_pkg::STRAP_SETTLE_CLKS) begin
            nxt_cur.strap_valid = 1'b1;
            nxt_cur.mode = decode_strap(strap_s);
         end else begin
            nxt_cur.settle = cur_ff.settle + 3'h1;
         end
      end
      // Memory store finishes when the memory side takes it
      if (cur_ff.mvalid && mem_wr_ready) begin
         nxt_cur.mvalid = 1'b0;
         nxt_cur.maddr = cur_ff.maddr + (wide ? hpms_pkg::ADDR_STEP_WIDE
                                             : hpms_pkg::ADDR_STEP_NARROW);
      end
      case (cur_ff.st)
         hpms_pkg::HPMS_IDLE: begin
            if (strobe) begin
               nxt_cur.st = hpms_pkg::HPMS_HELD;
               if (!ctl_s[3] && !rd_dir) begin
                  nxt_cur.index = db_s[7:0];
                  if (db_s[7:0] == hpms_pkg::IDX_MEMPORT) begin
                     nxt_cur.maddr = mem_start_addr;
                  end
               end else if (!ctl_s[3]) begin
                  nxt_cur.dout = {8'h00, status_in};
               end else if (rd_dir) begin
                  nxt_cur.dout = {8'h00, cur_ff.regs[cur_ff.index]};
               end else if (cur_ff.index == hpms_pkg::IDX_MEMPORT) begin
                  nxt_cur.mdata = wide ? db_s : {8'h00, db_s[7:0]};
                  nxt_cur.mvalid = 1'b1;
                  nxt_cur.st = hpms_pkg::HPMS_MEMW;
               end else if (cur_ff.index == hpms_pkg::IDX_SWRST) begin
                  // Restart request pulses and reads back as zero
                  nxt_cur.restart = db_s[hpms_pkg::BIT_SWRST];
                  nxt_cur.regs[hpms_pkg::IDX_SWRST] = db_s[7:0] & 8'hFE;
               end else begin
                  nxt_cur.regs[cur_ff.index] = db_s[7:0];
               end
            end
         end
         hpms_pkg::HPMS_MEMW: begin
            // Stay until the store is taken; wait stays low meanwhile
            if (!cur_ff.mvalid || mem_wr_ready) begin
               nxt_cur.st = hpms_pkg::HPMS_HELD;
            end
         end
         hpms_pkg::HPMS_HELD: begin
            // One access per strobe; wait for its end
            if (!strobe) begin
               nxt_cur.st = hpms_pkg::HPMS_IDLE;
            end
         end
         default: begin
            nxt_cur.st = hpms_pkg::HPMS_IDLE;
         end
      endcase
   end

   // State register; only sys_rst clears it, the restart pulse leaves it alone
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cur_ff.strap_valid <= 1'b0;
         cur_ff.settle <= 3'h0;
         cur_ff.mode <= hpms_pkg::HPMS_M8080;
         cur_ff.st <= hpms_pkg::HPMS_IDLE;
         cur_ff.index <= hpms_pkg::REG_RST_VAL;
         cur_ff.regs <= '0;
         cur_ff.dout <= hpms_pkg::DATA_RST_VAL;
         cur_ff.mdata <= hpms_pkg::DATA_RST_VAL;
         cur_ff.maddr <= hpms_pkg::ADDR_RST_VAL;
         cur_ff.mvalid <= 1'b0;
         cur_ff.restart <= 1'b0;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   // Pin sharing and outputs
   always_comb begin
      is_serial = cur_ff.strap_valid && !par_mode;
      mode_onehot = cur_ff.mode;
      int_n = irq_n;
      // Wait is low only in a memory store that is not yet taken
      wait_n = !(par_mode && cur_ff.st == hpms_pkg::HPMS_MEMW);
      core_restart = cur_ff.restart;
      mem_wr_valid = cur_ff.mvalid;
      mem_wr_data = cur_ff.mdata;
      mem_wr_addr = cur_ff.maddr;
      host_data_bus_out = cur_ff.dout;
      host_data_bus_oe_n = 16'hFFFF;
      ctrl_pin_out = aux_port_ctrl_out;
      ctrl_pin_oe_n = 4'hF;
      aux_port_upper_in = 8'h00;
      aux_port_ctrl_in = 4'h0;
      serial_clock = 1'b0;
      serial_data_in = 1'b0;
      serial_chip_select_n = 1'b1;
      i2c_address_strap = 6'h00;
      if (par_mode) begin
         // Drive the bus while a read cycle is held
         if (strobe && rd_dir && cur_ff.st == hpms_pkg::HPMS_HELD) begin
            host_data_bus_oe_n = wide ? 16'h0000 : 16'hFF00;
         end
      end else if (is_serial) begin
         host_data_bus_out = {aux_port_upper_out, 2'b00, serial_data_out, 5'h00};
         host_data_bus_oe_n[15:8] = ~aux_port_upper_oe;
         ctrl_pin_oe_n = ~aux_port_ctrl_oe;
         aux_port_upper_in = db_s[15:8];
         aux_port_ctrl_in = ctl_s;
         serial_clock = db_s[7];
         if (cur_ff.mode == hpms_pkg::HPMS_MI2C) begin
            serial_data_in = db_s[6];
            i2c_address_strap = db_s[5:0];
         end else begin
            serial_chip_select_n = db_s[4];
            serial_data_in = (cur_ff.mode == hpms_pkg::HPMS_MSPI4) ? db_s[6] : db_s[5];
            host_data_bus_oe_n[5] = !serial_data_oe;
         end
      end
   end
endmodule // hpms_host_port

// ==== rtl/hpms_pin_sync.sv ====
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Inputs are asynchronous to clk
// Notes: Output changes only when stages two and three agree
`timescale 1ns/1ps
module hpms_pin_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [W-1:0] pin,
   output logic [W-1:0] q
);
   logic [W-1:0] s1_ff; // Metastable stage, read only by s2
   logic [W-1:0] s2_ff; // Second stage
   logic [W-1:0] s3_ff; // Third stage
   // Chain and filter; a single-cycle glitch past s2 never reaches q
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
         q <= '0;
      end else begin
         s1_ff <= pin;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         for (int i = 0; i < W; i++) begin
            if (s2_ff[i] == s3_ff[i]) begin
               q[i] <= s3_ff[i];
            end
         end
      end
   end
endmodule // hpms_pin_sync

// ==== rtl/hpms_pkg.sv ====
// Purpose: Shared constants and types of the host port mode select block
// Assumes: Core clock of 25 MHz, registers of 8 bits, memory data of 16 bits
// Notes: Offsets, reset values and cycle counts live here only
package hpms_pkg;
   // Strap decode values
   localparam logic [2:0] STRAP_SPI3 = 3'h4; // Three-wire serial
   localparam logic [2:0] STRAP_SPI4 = 3'h5; // Four-wire serial
   // Register indices
   localparam logic [7:0] IDX_SWRST = 8'h00; // Bit 0 asks for a core restart
   localparam logic [7:0] IDX_CFG = 8'h01; // Bit 0 picks 8 or 16 bit width
   localparam logic [7:0] IDX_MEMPORT = 8'h04; // Memory data port
   localparam int BIT_SWRST = 0; // Field position of restart request
   localparam int BIT_WIDE = 0; // Field position of width select
   localparam int NUM_REGS = 256; // Indexed register count
   localparam logic [7:0] REG_RST_VAL = 8'h00; // Value after reset
   localparam logic [15:0] DATA_RST_VAL = 16'h0000; // Data latch after reset
   localparam logic [23:0] ADDR_RST_VAL = 24'h00_0000; // Memory address after reset
   localparam logic [23:0] ADDR_STEP_NARROW = 24'h00_0001; // Bytes per 8-bit write
   localparam logic [23:0] ADDR_STEP_WIDE = 24'h00_0002; // Bytes per 16-bit write
   // Host timing figures
   localparam int CORE_CLK_HZ = 25_000_000; // Core clock rate
   localparam int HOLD_RST_CLKS = 256; // Least external reset length
   localparam int SLOW_HOST_CLKS = 5; // Cycle must exceed this without wait
   // The pin filter needs four edges to pass the straps; one spare edge is margin
   localparam logic [2:0] STRAP_SETTLE_CLKS = 3'h5; // Clocks before the strap is taken
   // Protocol mode, one-hot
   typedef enum logic [4:0] {
      HPMS_M8080 = 5'b00001,
      HPMS_M6800 = 5'b00010,
      HPMS_MSPI3 = 5'b00100,
      HPMS_MSPI4 = 5'b01000,
      HPMS_MI2C = 5'b10000
   } hpms_mode_t;
   // Access sequencer, one-hot
   typedef enum logic [2:0] {
      HPMS_IDLE = 3'b001, // Waiting for a strobe
      HPMS_HELD = 3'b010, // Strobe taken, waiting for its end
      HPMS_MEMW = 3'b100 // Memory write waiting for the store
   } hpms_state_t;
endpackage

// ==== verification/hpms_host_model.sv ====
// Purpose: Behavioural host processor on the parallel port
// Assumes: Strobes pass a three-flop filter inside the device
// Notes: Holds each strobe and each gap for eight clocks, past the filter
`timescale 1ns/1ps
module hpms_host_model (
   input wire logic clk,
   input wire logic m6800,
   output logic [3:0] ctrl_pin_in,
   output logic [15:0] host_data_bus_in,
   input wire logic [15:0] host_data_bus_out,
   input wire logic [15:0] host_data_bus_oe_n,
   input wire logic wait_n
);
   logic [15:0] hd = 16'hFFFF; // Host drive value
   logic act = 1'b0; // Strobe phase of an access
   logic [3:0] req = 4'hF; // Select, direction, strobe, chip select
   // Idle: chip select high, strobe inactive in either protocol
   assign ctrl_pin_in = act ? req : {2'b11, ~m6800, 1'b1};
   // Pin level: the device wins wherever it enables its driver
   assign host_data_bus_in = (~host_data_bus_oe_n & host_data_bus_out) | (host_data_bus_oe_n & hd);
   // One access cycle, held until the device stops waiting
   task automatic access(input logic sel, input logic rd, input logic [15:0] d,
         output logic [15:0] q, output logic [15:0] qoe);
      int n;
      @(posedge clk);
      hd <= rd ? ~hd : d; // Released bus never shows the old value
      req <= {sel, rd, m6800 | ~rd, 1'b0};
      act <= 1'b1;
      repeat (8) @(posedge clk);
      n = 0;
      while (wait_n !== 1'b1 && n < 64) begin
         @(posedge clk);
         n++;
      end
      q = host_data_bus_out;
      qoe = host_data_bus_oe_n;
      act <= 1'b0;
      repeat (8) @(posedge clk);
   endtask
endmodule // hpms_host_model

// ==== verification/hpms_host_port_asserts.sv ====
// Purpose: Port-level checks of the host port front end
// Assumes: One clock domain, asynchronous active-high reset
// Notes: Strap capture settles within eight clocks of reset release
`timescale 1ns/1ps
module hpms_host_port_chk (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic irq_n,
   input wire logic int_n,
   input wire logic wait_n,
   input wire logic is_serial,
   input wire logic [4:0] mode_onehot,
   input wire logic core_restart,
   input wire logic mem_wr_valid,
   input wire logic mem_wr_ready,
   input wire logic [15:0] mem_wr_data,
   input wire logic [23:0] mem_wr_addr,
   input wire logic [15:0] host_data_bus_out,
   input wire logic [15:0] host_data_bus_oe_n,
   input wire logic [7:0] aux_port_upper_out,
   input wire logic [7:0] aux_port_upper_oe,
   input wire logic [3:0] ctrl_pin_oe_n
);
   logic [3:0] age_ff; // Clocks since reset, saturating at eight
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // Age counter; mode may still move while the strap filter fills
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) age_ff <= 4'h0;
      else if (age_ff != 4'h8) age_ff <= age_ff + 4'h1;
   end
   a_mode_legal: assert property ($onehot(mode_onehot) && is_serial == |mode_onehot[4:2])
      else $error("mode outputs inconsistent");
   a_mode_fixed: assert property (age_ff == 4'h8 |-> $stable(mode_onehot))
      else $error("mode changed after capture");
   a_gpio_map: assert property (is_serial |-> host_data_bus_out[15:8] == aux_port_upper_out
      && host_data_bus_oe_n[15:8] == ~aux_port_upper_oe) else $error("upper pins not gpio");
   a_ctrl_float: assert property (!is_serial |-> ctrl_pin_oe_n == 4'hF)
      else $error("control pins driven in parallel mode");
   a_width_oe: assert property (!is_serial |-> host_data_bus_oe_n inside
      {16'h0000, 16'hFF00, 16'hFFFF}) else $error("bad data pin enables");
   a_wait_busy: assert property (mem_wr_valid && !mem_wr_ready |-> !wait_n)
      else $error("wait high with store pending");
   a_store_hold: assert property (mem_wr_valid && !mem_wr_ready |=> mem_wr_valid
      && $stable(mem_wr_addr) && $stable(mem_wr_data)) else $error("store dropped");
   a_restart_pulse: assert property ($rose(core_restart) |=> !core_restart)
      else $error("restart longer than one clock");
   a_int_pass: assert property (int_n == irq_n)
      else $error("interrupt pin not passed");
   c_store: cover property (mem_wr_valid && mem_wr_ready);
   c_restart: cover property (core_restart);
   c_serial: cover property (is_serial && age_ff == 4'h8);
endmodule // hpms_host_port_chk
bind hpms_host_port hpms_host_port_chk u_chk (.clk(clk), .sys_rst(sys_rst), .irq_n(irq_n),
   .int_n(int_n), .wait_n(wait_n), .is_serial(is_serial), .mode_onehot(mode_onehot),
   .core_restart(core_restart), .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready),
   .mem_wr_data(mem_wr_data), .mem_wr_addr(mem_wr_addr), .host_data_bus_out(host_data_bus_out),
   .host_data_bus_oe_n(host_data_bus_oe_n), .aux_port_upper_out(aux_port_upper_out),
   .aux_port_upper_oe(aux_port_upper_oe), .ctrl_pin_oe_n(ctrl_pin_oe_n));

// ==== verification/tb_top.sv ====
// Purpose: Self-checking bench of the host port front end
// Assumes: Memory side stalls one clock on every store
// Notes: Rows cover every strap code; parallel runs follow
`timescale 1ns/1ps
module tb_top;
   logic clk = 1'b0, sys_rst = 1'b1, irq_n = 1'b1, mem_wr_ready = 1'b0, m6800 = 1'b0;
   logic [2:0] host_protocol_strap = 3'h0;
   logic [15:0] host_data_bus_in, host_data_bus_out, host_data_bus_oe_n, mem_wr_data, q, qoe;
   logic [3:0] ctrl_pin_in, ctrl_pin_out, ctrl_pin_oe_n, aux_port_ctrl_in;
   logic [3:0] aux_port_ctrl_out = 4'h5, aux_port_ctrl_oe = 4'h0;
   logic [7:0] status_in = 8'h02, aux_port_upper_in, aux_port_upper_out = 8'hC3;
   logic [7:0] aux_port_upper_oe = 8'h0F;
   logic [4:0] mode_onehot;
   logic [5:0] i2c_address_strap;
   logic [23:0] mem_start_addr = 24'h00_1000, mem_wr_addr;
   logic wait_n, int_n, is_serial, serial_clock, serial_data_in, serial_chip_select_n;
   logic core_restart, mem_wr_valid, serial_data_out = 1'b0, serial_data_oe = 1'b0;
   int fail_count = 0, check_count = 0, restarts = 0;
   logic [39:0] stores[$]; // Address and data of each store taken
   logic [4:0] mode_rows [8] = '{5'h01, 5'h01, 5'h02, 5'h02, 5'h04, 5'h08, 5'h10, 5'h10};
   always #20 clk = ~clk;
   hpms_host_port dut (.clk, .sys_rst, .host_protocol_strap, .host_data_bus_in,
      .host_data_bus_out, .host_data_bus_oe_n, .ctrl_pin_in, .ctrl_pin_out, .ctrl_pin_oe_n,
      .wait_n, .irq_n, .int_n, .status_in, .mode_onehot, .is_serial, .serial_clock,
      .serial_data_in, .serial_chip_select_n, .i2c_address_strap, .serial_data_out,
      .serial_data_oe, .aux_port_upper_in, .aux_port_upper_out, .aux_port_upper_oe,
      .aux_port_ctrl_in, .aux_port_ctrl_out, .aux_port_ctrl_oe, .core_restart, .mem_start_addr,
      .mem_wr_valid, .mem_wr_data, .mem_wr_addr, .mem_wr_ready);
   hpms_host_model host (.clk, .m6800, .ctrl_pin_in, .host_data_bus_in, .host_data_bus_out,
      .host_data_bus_oe_n, .wait_n);
   // Memory side: one stall clock exercises the wait handshake
   always @(posedge clk) begin
      mem_wr_ready <= mem_wr_valid && !mem_wr_ready;
      if (mem_wr_valid && mem_wr_ready) stores.push_back({mem_wr_addr, mem_wr_data});
      if (core_restart === 1'b1) restarts++;
   end
   task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("checks=%0d mismatches=%0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Reset with straps held stable across release
   task automatic do_reset(input logic [2:0] s, input int n);
      sys_rst <= 1'b1;
      host_protocol_strap <= s;
      m6800 <= (s[2:1] == 2'b01);
      repeat (n) @(posedge clk);
      chk({wait_n, host_data_bus_oe_n, ctrl_pin_oe_n}, {1'b1, 16'hFFFF, 4'hF});
      sys_rst <= 1'b0;
      repeat (8) @(posedge clk);
   endtask
   task automatic wreg(input logic [7:0] i, input logic [15:0] d);
      host.access(1'b0, 1'b0, {8'h00, i}, q, qoe);
      host.access(1'b1, 1'b0, d, q, qoe);
   endtask
   task automatic rreg(input logic [7:0] i);
      host.access(1'b0, 1'b0, {8'h00, i}, q, qoe);
      host.access(1'b1, 1'b1, 16'h0000, q, qoe);
   endtask
   // Register, width, memory and restart traffic in one parallel protocol
   task automatic par_run(input logic [2:0] s);
      do_reset(s, 4);
      stores.delete();
      restarts = 0;
      host.access(1'b0, 1'b1, 16'h0000, q, qoe);
      chk(q[7:0], 8'h02);
      wreg(8'hFF, 16'h005A);
      rreg(8'hFF);
      chk(q[7:0], 8'h5A);
      wreg(8'h01, 16'h0001);
      rreg(8'h01);
      chk({q[7:0], qoe}, {8'h01, 16'h0000});
      host.access(1'b0, 1'b0, 16'h0004, q, qoe);
      host.access(1'b1, 1'b0, 16'h1234, q, qoe);
      host.access(1'b1, 1'b0, 16'hABCD, q, qoe);
      wreg(8'h01, 16'h0000);
      rreg(8'h01);
      chk(qoe, 16'hFF00);
      host.access(1'b0, 1'b0, 16'h0004, q, qoe);
      host.access(1'b1, 1'b0, 16'h0077, q, qoe);
      host.access(1'b1, 1'b0, 16'h0088, q, qoe);
      chk(stores.size(), 4);
      chk(stores[0], {mem_start_addr, 16'h1234});
      chk(stores[1], {mem_start_addr + hpms_pkg::ADDR_STEP_WIDE, 16'hABCD});
      chk({stores[2][39:16], stores[2][7:0]}, {mem_start_addr, 8'h77});
      chk({stores[3][39:16], stores[3][7:0]}, {mem_start_addr + 24'h00_0001, 8'h88});
      wreg(8'h00, 16'h0001);
      rreg(8'h00);
      chk({q[7:0], restarts[7:0]}, {8'h00, 8'h01});
   endtask
   initial begin
      do_reset(3'h0, 4);
      for (int s = 0; s < 8; s++) begin
         do_reset(s[2:0], hpms_pkg::HOLD_RST_CLKS);
         host.hd <= 16'h5AB6;
         irq_n <= s[0];
         serial_data_oe <= s[0];
         repeat (6) @(posedge clk);
         chk(mode_onehot, mode_rows[s]);
         chk(int_n, s[0]);
         if (s >= 4) begin
            chk(aux_port_upper_in, 8'h53);
            chk(aux_port_ctrl_in, ctrl_pin_in);
            chk({ctrl_pin_out, ctrl_pin_oe_n}, {4'h5, 4'hF});
            chk(host_data_bus_oe_n[7:0], {2'b11, s != 5, 5'h1F});
            chk({serial_clock, serial_data_in}, {1'b1, s == 4});
            if (s >= 6) chk(i2c_address_strap, 6'h36);
            else chk(serial_chip_select_n, 1'b1);
         end
      end
      par_run(3'h1);
      par_run(3'h3);
      report_and_stop();
   end
   // Watchdog well beyond the expected run of about three thousand clocks
   initial begin
      repeat (40000) @(posedge clk);
      fail_count++;
      report_and_stop();
   end
endmodule // tb_top
